// File: crcg_clock_gate.sv
`default_nettype none
module crcg_clock_gate
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_enable,
  output logic o_gclk
);
  logic en_latch;
  // enable changes only while clock is low
  always_latch
  begin
    if (!i_clk)
      en_latch = i_enable & i_rst_n;
  end
  assign o_gclk = i_clk & en_latch;
endmodule // crcg_clock_gate
`default_nettype wire

// File: crcg_core_rate.sv
// Behaviour
// - core start pulse comes from internal rate, serial pair frame clock or receiver
// - codes 0,1,2 select normal, dual and quad internal rates
// - codes 3 to 14 select serial input pairs 0 to 11
// - codes 15 to 26 select serial output pairs 0 to 11
// - code 27 selects the receiver's recovered frame clock
// - codes 28 to 31 give no start pulse, core disabled
// - select resets to normal rate, 3584 core cycles per frame
// - clock enable bit 0 is off, 1 is on, resets to 0
// - bits 0,1,2 gate routing matrix, serial inputs, serial outputs
// - bits 3,4 gate rate converter groups, bit 5 the core
// - bits 6,7,8 gate receiver, transmitter, aux converters; rest reserved
// - external source selected: core frames follow that frame clock
// - core clock is 56 times a 64x normal rate clock
`include "crcg_defines.svh"
`default_nettype none
module crcg_core_rate
  import crcg_pkg::*;
#(
  parameter int unsigned N_PAIRS = 12,
  parameter int unsigned N_GATES = `CRCG_CLK_EN_W,
  parameter int unsigned CYC_NORMAL = `CRCG_CYC_NORMAL
)
(
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [15:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic [N_PAIRS-1:0] i_sin_frame,
  input wire logic [N_PAIRS-1:0] i_sout_frame,
  input wire logic i_spdif_frame,
  output logic [15:0] o_rdata,
  output logic o_start,
  output logic o_core_enabled,
  output logic [N_GATES-1:0] o_gclk
);
  localparam int unsigned CYC_DUAL = CYC_NORMAL / 2;
  localparam int unsigned CYC_QUAD = CYC_NORMAL / 4;
  localparam int unsigned CW = $clog2(CYC_NORMAL);
  localparam logic [15:0] SEL_RST = `CRCG_RATE_SEL_RST;
  localparam logic [15:0] EN_RST = `CRCG_CLK_EN_RST;
  // frame length is 56 x 64 core cycles at normal rate
  localparam int unsigned CYC_PLL = 56 * 64;

  logic rst_meta;
  logic rst_sync_n;
  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      rst_meta <= 1'b0;
      rst_sync_n <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_sync_n <= rst_meta;
    end
  end

  logic [`CRCG_SEL_W-1:0] sel_reg;
  logic [N_GATES-1:0] clk_en_reg;
  logic [15:0] rdata_reg;
  wire sel_hit = i_addr == `CRCG_ADDR_RATE_SEL;
  wire en_hit = i_addr == `CRCG_ADDR_CLK_EN;

  always_ff @(posedge i_mclk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      sel_reg <= SEL_RST[`CRCG_SEL_W-1:0];
      clk_en_reg <= EN_RST[N_GATES-1:0];
    end
    else if (i_wr)
    begin
      if (sel_hit)
        sel_reg <= i_wdata[`CRCG_SEL_LSB +: `CRCG_SEL_W];
      if (en_hit)
        clk_en_reg <= i_wdata[N_GATES-1:0];
    end
  end

  wire [15:0] rd_mux = sel_hit ? {11'h000, sel_reg} :
                       en_hit ? {{(16-N_GATES){1'b0}}, clk_en_reg} : 16'h0000;
  always_ff @(posedge i_mclk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      rdata_reg <= 16'h0000;
    else if (i_rd)
      rdata_reg <= rd_mux;
  end
  assign o_rdata = rdata_reg;

  // external frame clocks: two-stage sync, then edge
  logic [2*N_PAIRS:0] fr_meta;
  logic [2*N_PAIRS:0] fr_sync;
  logic [2*N_PAIRS:0] fr_last;
  always_ff @(posedge i_mclk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      fr_meta <= '0;
      fr_sync <= '0;
      fr_last <= '0;
    end
    else
    begin
      fr_meta <= {i_spdif_frame, i_sout_frame, i_sin_frame};
      fr_sync <= fr_meta;
      fr_last <= fr_sync;
    end
  end
  wire [2*N_PAIRS:0] fr_rise = fr_sync & ~fr_last;

  crcg_src_t src;
  wire [4:0] ext_idx = sel_reg - `CRCG_SEL_SIN0;
  // codes above receiver give no pulse
  assign src = (sel_reg > `CRCG_SEL_SPDIF) ? CRCG_SRC_OFF :
               (sel_reg >= `CRCG_SEL_SIN0) ? CRCG_SRC_EXTERNAL : CRCG_SRC_INTERNAL;

  function automatic logic [CW-1:0] period_of(input logic [4:0] code);
    case (code)
      `CRCG_SEL_DUAL: period_of = CW'(CYC_DUAL - 1);
      `CRCG_SEL_QUAD: period_of = CW'(CYC_QUAD - 1);
      default: period_of = CW'(CYC_NORMAL - 1);
    endcase
  endfunction

  logic [CW-1:0] cnt_reg;
  wire [CW-1:0] period = period_of(sel_reg);
  wire int_tick = src == CRCG_SRC_INTERNAL && cnt_reg >= period;
  // external frame edge picks the pulse
  wire ext_tick = src == CRCG_SRC_EXTERNAL && fr_rise[ext_idx];
  logic start_reg;
  logic core_en_reg;
  always_ff @(posedge i_mclk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      cnt_reg <= '0;
      start_reg <= 1'b0;
      core_en_reg <= 1'b0;
    end
    else
    begin
      cnt_reg <= (int_tick || src != CRCG_SRC_INTERNAL) ? '0 : cnt_reg + 1'b1;
      start_reg <= int_tick | ext_tick;
      core_en_reg <= src != CRCG_SRC_OFF;
    end
  end
  assign o_start = start_reg;
  assign o_core_enabled = core_en_reg;

  for (genvar g = 0; g < N_GATES; g++)
  begin : g_gate
    crcg_clock_gate u_gate (
      .i_clk(i_mclk),
      .i_rst_n(rst_sync_n),
      .i_enable(clk_en_reg[g]),
      .o_gclk(o_gclk[g])
    );
  end

  normal_period_a: assert property (@(posedge i_mclk) disable iff (!rst_sync_n)
    (sel_reg == `CRCG_SEL_NORMAL && $stable(sel_reg) && start_reg && $past(src) == CRCG_SRC_INTERNAL)
    |-> ##1 !start_reg [*8]) else $error("normal start too soon");
  no_pulse_off_a: assert property (@(posedge i_mclk) disable iff (!rst_sync_n)
    (src == CRCG_SRC_OFF) [*2] |=> !start_reg) else $error("start while core off");
  en_write_a: assert property (@(posedge i_mclk) disable iff (!rst_sync_n)
    (i_wr && en_hit) |=> clk_en_reg == $past(i_wdata[N_GATES-1:0])) else $error("enable lost");
  int_pulse_a: assert property (@(posedge i_mclk) disable iff (!rst_sync_n)
    (src == CRCG_SRC_INTERNAL && int_tick) |=> start_reg) else $error("internal pulse lost");
  ext_pulse_a: assert property (@(posedge i_mclk) disable iff (!rst_sync_n)
    ext_tick |=> start_reg) else $error("external pulse lost");
  // internal pulses absent when external selected
  ext_only_a: assert property (@(posedge i_mclk) disable iff (!rst_sync_n)
    (src == CRCG_SRC_EXTERNAL && !ext_tick) |=> !start_reg) else $error("stray pulse");
  spdif_ext_a: assert property (@(posedge i_mclk) disable iff (!rst_sync_n)
    sel_reg == `CRCG_SEL_SPDIF |-> src == CRCG_SRC_EXTERNAL) else $error("receiver not external");
  resv_zero_a: assert property (@(posedge i_mclk) disable iff (!rst_sync_n)
    (i_rd && en_hit) |=> o_rdata[15:N_GATES] == '0) else $error("reserved bits set");
  // default frame length matches the multiplied clock
  pll_ratio_a: assert property (@(posedge i_mclk) disable iff (!rst_sync_n)
    (CYC_NORMAL != `CRCG_CYC_NORMAL) || (CYC_NORMAL == CYC_PLL)) else $error("frame length");
  cov_dual_c: cover property (@(posedge i_mclk) sel_reg == `CRCG_SEL_DUAL && start_reg);
  cov_ext_c: cover property (@(posedge i_mclk) ext_tick);
  cov_off_c: cover property (@(posedge i_mclk) src == CRCG_SRC_OFF);
endmodule // crcg_core_rate
`default_nettype wire

// File: crcg_core_rate_tb_top.sv
`include "crcg_defines.svh"
`default_nettype none
`define CHK(nm, e, g) \
  begin \
    cmp_count++; \
    if ((g) !== (e)) \
    begin \
      miscompares++; \
      $display("[FAIL] %s expected %0h seen %0h", nm, e, g); \
    end \
  end
module crcg_core_rate_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int CYCN = 64;
  localparam logic [15:0] A_SEL = `CRCG_ADDR_RATE_SEL;
  localparam logic [15:0] A_EN = `CRCG_ADDR_CLK_EN;
  logic i_mclk = 1'b0;
  logic i_rst_n = 1'b0;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [15:0] i_addr = 16'h0000;
  logic [15:0] i_wdata = 16'h0000;
  // frame levels: [11:0] inputs, [23:12] outputs, [24] receiver
  logic [24:0] fr = 25'h0000000;
  wire logic [15:0] o_rdata;
  wire logic o_start;
  wire logic o_core_enabled;
  wire logic [8:0] o_gclk;
  int miscompares = 0;
  int cmp_count = 0;
  int n;
  crcg_core_rate #(.CYC_NORMAL(CYCN)) dut
  (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .i_wr(i_wr),
    .i_rd(i_rd),
    .i_addr(i_addr),
    .i_wdata(i_wdata),
    .i_sin_frame(fr[11:0]),
    .i_sout_frame(fr[23:12]),
    .i_spdif_frame(fr[24]),
    .o_rdata(o_rdata),
    .o_start(o_start),
    .o_core_enabled(o_core_enabled),
    .o_gclk(o_gclk)
  );
  initial
  begin
    forever #2 i_mclk = ~i_mclk;
  end
  task report_and_stop;
    if (miscompares == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task wr(input logic [15:0] a, input logic [15:0] d);
    @(negedge i_mclk);
    i_wr = 1'b1;
    i_addr = a;
    i_wdata = d;
    @(negedge i_mclk);
    i_wr = 1'b0;
  endtask
  task chk_rd(input logic [15:0] a, input logic [15:0] e);
    @(negedge i_mclk);
    i_rd = 1'b1;
    i_addr = a;
    @(negedge i_mclk);
    i_rd = 1'b0;
    `CHK("rdata", e, o_rdata)
  endtask
  // falling edges until a start pulse, 400 means none
  task wait_start(output int k);
    k = 0;
    do
    begin
      @(negedge i_mclk);
      k++;
    end
    while (o_start !== 1'b1 && k < 400);
  endtask
  initial
  begin
    repeat (40000) @(posedge i_mclk);
    miscompares++;
    report_and_stop;
  end
  initial
  begin
    repeat (16) @(negedge i_mclk);
    i_rst_n = 1'b1;
    repeat (4) @(negedge i_mclk);
    chk_rd(A_EN, 16'h0000);
    chk_rd(A_SEL, 16'h0000);
    `CHK("core_en", 1'b1, o_core_enabled)
    wait_start(n);
    wait_start(n);
    `CHK("period", CYCN, n)
    for (int i = 0; i < 9; i++)
    begin
      wr(A_EN, 16'h0001 << i);
      repeat (2) @(posedge i_mclk);
      #1 `CHK("gclk_high", 9'(1 << i), o_gclk)
      @(negedge i_mclk);
      #1 `CHK("gclk_low", 9'h000, o_gclk)
    end
    wr(A_EN, 16'hFFFF);
    chk_rd(A_EN, 16'h01FF);
    wr(16'hE221, 16'h0002);
    chk_rd(16'hE221, 16'h0000);
    chk_rd(A_SEL, 16'h0000);
    wr(A_SEL, 16'hFFE1);
    chk_rd(A_SEL, 16'h0001);
    wait_start(n);
    wait_start(n);
    `CHK("period_dual", CYCN / 2, n)
    wr(A_SEL, 16'h0002);
    wait_start(n);
    wait_start(n);
    `CHK("period_quad", CYCN / 4, n)
    // other sources high first must not pace the core
    for (int c = 3; c < 28; c++)
    begin
      wr(A_SEL, 16'(c));
      fr = ~(25'h0000001 << (c - 3));
      wait_start(n);
      `CHK("other_src", 400, n)
      fr = 25'h1FFFFFF;
      wait_start(n);
      `CHK("ext_start", 3, n)
      fr = 25'h0000000;
      repeat (8) @(negedge i_mclk);
    end
    fr = 25'h1FFFFFF;
    for (int c = 28; c < 32; c++)
    begin
      wr(A_SEL, 16'(c));
      repeat (2) @(negedge i_mclk);
      `CHK("core_off", 1'b0, o_core_enabled)
      wait_start(n);
      `CHK("no_start", 400, n)
    end
    report_and_stop;
  end
endmodule // crcg_core_rate_tb_top
`default_nettype wire

// File: crcg_defines.svh
`ifndef CRCG_DEFINES_SVH
`define CRCG_DEFINES_SVH
`define CRCG_ADDR_RATE_SEL 16'hE220
`define CRCG_ADDR_CLK_EN 16'hE280
`define CRCG_RATE_SEL_RST 16'h0000
`define CRCG_CLK_EN_RST 16'h0000
`define CRCG_SEL_LSB 0
`define CRCG_SEL_W 5
`define CRCG_CLK_EN_W 9
`define CRCG_SEL_NORMAL 5'h00
`define CRCG_SEL_DUAL 5'h01
`define CRCG_SEL_QUAD 5'h02
`define CRCG_SEL_SIN0 5'h03
`define CRCG_SEL_SOUT0 5'h0F
`define CRCG_SEL_SPDIF 5'h1B
`define CRCG_CYC_NORMAL 3584
`define CRCG_CYC_DUAL 1792
`define CRCG_CYC_QUAD 896
`define CRCG_BIT_ROUTING 0
`define CRCG_BIT_SIN 1
`define CRCG_BIT_SOUT 2
`define CRCG_BIT_SRC_LO 3
`define CRCG_BIT_SRC_HI 4
`define CRCG_BIT_CORE 5
`define CRCG_BIT_SPDIF_RX 6
`define CRCG_BIT_SPDIF_TX 7
`define CRCG_BIT_AUX 8
`endif

// File: crcg_pkg.sv
`default_nettype none
package crcg_pkg;
  typedef enum logic [1:0] {CRCG_SRC_INTERNAL, CRCG_SRC_EXTERNAL, CRCG_SRC_OFF} crcg_src_t;
endpackage
`default_nettype wire
